// file: hw/cpw_consts.svh
`ifndef CPW_CONSTS_SVH
`define CPW_CONSTS_SVH

// ****************************************
// Register map
// ****************************************
`define CPW_ADDR_W 4
`define CPW_OFF_UNIT_CONTROL 4'h0
`define CPW_OFF_CMP_LOW 4'h1
`define CPW_OFF_CMP_HIGH 4'h2
`define CPW_OFF_TMRA_LOW 4'h3
`define CPW_OFF_TMRA_HIGH 4'h4
`define CPW_OFF_STATUS 4'h5
`define CPW_OFF_PERIOD 4'h6
`define CPW_OFF_TMRB_CTRL 4'h7
`define CPW_OFF_PIN_REMAP 4'h8
`define CPW_OFF_PIN_DIR 4'h9
`define CPW_OFF_TMRB_COUNT 4'hA

// ****************************************
// Field positions
// ****************************************
`define CPW_UC_MODE_LSB 0
`define CPW_UC_DUTY_LSB 4
`define CPW_ST_MATCH_BIT 0
`define CPW_ST_OVF_BIT 1
`define CPW_TBC_ON_BIT 2

// ****************************************
// Reset values
// ****************************************
`define CPW_RST_BYTE 8'h00
`define CPW_RST_WORD 16'h0000
`define CPW_RST_PERIOD 8'hFF
`define CPW_RST_TBC 3'h0
`define CPW_RST_DIR 1'h1

// ****************************************
// Timing counts
// ****************************************
`define CPW_TMRA_MAX 16'hFFFF
`define CPW_PRE_1 6'h03
`define CPW_PRE_4 6'h0F
`define CPW_PRE_16 6'h3F

`endif

// file: hw/cpw_pkg.sv
`include "cpw_consts.svh"

package cpw_pkg;

  typedef enum logic [3:0] {
    CPW_MODE_OFF = 4'b0000,
    CPW_MODE_TOGGLE = 4'b0010,
    CPW_MODE_SET = 4'b1000,
    CPW_MODE_CLEAR = 4'b1001,
    CPW_MODE_SOFT = 4'b1010,
    CPW_MODE_SPECIAL = 4'b1011
  } cpw_mode_t;

  typedef enum logic {
    CPW_SEV_IDLE = 1'b0,
    CPW_SEV_PEND = 1'b1
  } cpw_sev_t;

  typedef logic [`CPW_ADDR_W-1:0] cpw_addr_t;

endpackage : cpw_pkg

// file: hw/cpw_pwm_if.sv
`timescale 1ns/1ps

interface cpw_pwm_if;
  logic enable;
  logic [7:0] period;
  logic [2:0] tb_ctrl;
  logic [9:0] duty;
  logic pwm_level;
  logic [7:0] duty_latched;
  logic [7:0] tb_count;

  modport main (
    output enable,
    output period,
    output tb_ctrl,
    output duty,
    input pwm_level,
    input duty_latched,
    input tb_count
  );

  modport pwm (
    input enable,
    input period,
    input tb_ctrl,
    input duty,
    output pwm_level,
    output duty_latched,
    output tb_count
  );
endinterface : cpw_pwm_if

// file: hw/cpw_pwm.sv
`timescale 1ns/1ps
`include "cpw_consts.svh"

module cpw_pwm (
  input wire logic clk_i,
  input wire logic srst_i,
  cpw_pwm_if.pwm pw
);
  import cpw_pkg::*;

  logic [5:0] pre_r;
  logic [5:0] pre_nxt;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic [9:0] lat_r;
  logic [9:0] lat_nxt;
  logic lvl_r;
  logic lvl_nxt;
  logic [9:0] base_nxt;
  wire run = pw.enable & pw.tb_ctrl[`CPW_TBC_ON_BIT];
  wire [5:0] pre_lim = (pw.tb_ctrl[1:0] == 2'b00) ? `CPW_PRE_1 :
                       (pw.tb_ctrl[1:0] == 2'b01) ? `CPW_PRE_4 : `CPW_PRE_16;
  wire step = run & (pre_r == pre_lim);
  wire wrap = step & (cnt_r == pw.period);
  always_comb
  begin
    pre_nxt = step ? 6'h00 : (run ? pre_r + 6'h01 : pre_r);
    cnt_nxt = wrap ? 8'h00 : (step ? cnt_r + 8'h01 : cnt_r);
    lat_nxt = wrap ? pw.duty : lat_r;
    // Compare the coming base, so the pin is already low while base equals duty
    case (pw.tb_ctrl[1:0])
      2'b00: base_nxt = {cnt_nxt, pre_nxt[1:0]};
      2'b01: base_nxt = {cnt_nxt, pre_nxt[3:2]};
      default: base_nxt = {cnt_nxt, pre_nxt[5:4]};
    endcase
    lvl_nxt = lvl_r;
    if (!pw.enable)
      lvl_nxt = 1'b0;
    else if (wrap)
      lvl_nxt = (pw.duty != 10'h000);
    else if (run && base_nxt == lat_nxt)
      lvl_nxt = 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      pre_r <= 6'h00;
      cnt_r <= 8'h00;
      lat_r <= 10'h000;
      lvl_r <= 1'b0;
    end
    else
    begin
      pre_r <= pre_nxt;
      cnt_r <= cnt_nxt;
      lat_r <= lat_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  assign pw.pwm_level = lvl_r;
  assign pw.duty_latched = lat_r[9:2];
  assign pw.tb_count = cnt_r;

endmodule : cpw_pwm

// file: hw/cpw_unit.sv
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "cpw_consts.svh"

module cpw_unit #(
  parameter int PIN_COUNT = 2
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire cpw_pkg::cpw_addr_t addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic timer_a_tick_i,
  input wire logic adc_enable_i,
  output logic special_event_o,
  output logic adc_start_o,
  output logic match_flag_o,
  output logic timer_a_overflow_flag_o,
  output logic [PIN_COUNT-1:0] unit_pin_o,
  output logic [PIN_COUNT-1:0] unit_pin_oe_o
);
  import cpw_pkg::*;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic hit(input cpw_addr_t a, input cpw_addr_t off);
    hit = (a == off);
  endfunction : hit

  function automatic logic is_compare(input logic [3:0] m);
    is_compare = (m == CPW_MODE_TOGGLE) || (m == CPW_MODE_SET) ||
                 (m == CPW_MODE_CLEAR) || (m == CPW_MODE_SOFT) ||
                 (m == CPW_MODE_SPECIAL);
  endfunction : is_compare

  // ****************************************
  // State
  // ****************************************
  logic [7:0] uc_r;
  logic [7:0] uc_nxt;
  logic [7:0] cvl_r;
  logic [7:0] cvl_nxt;
  logic [7:0] cvh_r;
  logic [7:0] cvh_nxt;
  logic [15:0] tmra_r;
  logic [15:0] tmra_nxt;
  logic match_r;
  logic match_nxt;
  logic ovf_r;
  logic ovf_nxt;
  logic eq_prev_r;
  logic latch_r;
  logic latch_nxt;
  logic [7:0] period_r;
  logic [7:0] period_nxt;
  logic [2:0] tbc_r;
  logic [2:0] tbc_nxt;
  logic [$clog2(PIN_COUNT)-1:0] remap_r;
  logic [$clog2(PIN_COUNT)-1:0] remap_nxt;
  logic dir_r;
  logic dir_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  cpw_sev_t sev_r;
  cpw_sev_t sev_nxt;

  cpw_pwm_if pwm_bus ();

  // ****************************************
  // Decode
  // ****************************************
  wire [3:0] mode = uc_r[`CPW_UC_MODE_LSB +: 4];
  wire pwm_mode = (mode[3:2] == 2'b11);
  wire cmp_mode = is_compare(mode);
  wire wr_uc = wr_i & hit(addr_i, `CPW_OFF_UNIT_CONTROL);
  wire wr_cvl = wr_i & hit(addr_i, `CPW_OFF_CMP_LOW);
  // High compare byte is read-only while PWM owns it
  wire wr_cvh = wr_i & hit(addr_i, `CPW_OFF_CMP_HIGH) & ~pwm_mode;
  wire wr_tal = wr_i & hit(addr_i, `CPW_OFF_TMRA_LOW);
  wire wr_tah = wr_i & hit(addr_i, `CPW_OFF_TMRA_HIGH);
  wire wr_st = wr_i & hit(addr_i, `CPW_OFF_STATUS);
  wire wr_pr = wr_i & hit(addr_i, `CPW_OFF_PERIOD);
  wire wr_tbc = wr_i & hit(addr_i, `CPW_OFF_TMRB_CTRL);
  wire wr_rm = wr_i & hit(addr_i, `CPW_OFF_PIN_REMAP);
  wire wr_dir = wr_i & hit(addr_i, `CPW_OFF_PIN_DIR);

  // ****************************************
  // Compare engine
  // ****************************************
  wire [15:0] cmp_val = {cvh_r, cvl_r};
  // Equality is only seen while clk_i runs
  wire eq = (tmra_r == cmp_val);
  // Edge of equality, so a slow timer resting on the value acts once
  wire match_ev = cmp_mode & eq & ~eq_prev_r;
  wire sev_ev = match_ev & (mode == CPW_MODE_SPECIAL);
  wire sev_armed = sev_ev | (sev_r == CPW_SEV_PEND);
  // Reset only if the match still stands at the timer edge
  wire tmra_clear = sev_armed & eq & timer_a_tick_i;
  wire tmra_wrap = timer_a_tick_i & ~tmra_clear & (tmra_r == `CPW_TMRA_MAX);
  wire st_clr_match = wr_st & wdata_i[`CPW_ST_MATCH_BIT];
  wire st_clr_ovf = wr_st & wdata_i[`CPW_ST_OVF_BIT];

  always_comb
  begin
    sev_nxt = sev_r;
    case (sev_r)
      CPW_SEV_IDLE:
      begin
        if (sev_ev && !tmra_clear)
          sev_nxt = CPW_SEV_PEND;
      end
      CPW_SEV_PEND:
      begin
        if (tmra_clear || !eq || mode != CPW_MODE_SPECIAL)
          sev_nxt = CPW_SEV_IDLE;
      end
      default:
        sev_nxt = CPW_SEV_IDLE;
    endcase
  end

  always_comb
  begin
    tmra_nxt = tmra_r;
    if (wr_tal)
      tmra_nxt = {tmra_r[15:8], wdata_i};
    else if (wr_tah)
      tmra_nxt = {wdata_i, tmra_r[7:0]};
    else if (tmra_clear)
      tmra_nxt = `CPW_RST_WORD;
    else if (timer_a_tick_i)
      tmra_nxt = tmra_r + 16'h0001;
  end

  // Set wins over a clear in the same cycle
  assign match_nxt = match_ev | (match_r & ~st_clr_match);
  // Trigger reset is excluded from wrap, so it never flags overflow
  assign ovf_nxt = tmra_wrap | (ovf_r & ~st_clr_ovf);

  always_comb
  begin
    latch_nxt = latch_r;
    if (uc_r == `CPW_RST_BYTE)
      latch_nxt = 1'b0;
    else if (match_ev)
    begin
      case (cpw_mode_t'(mode))
        CPW_MODE_TOGGLE: latch_nxt = ~latch_r;
        CPW_MODE_SET: latch_nxt = 1'b1;
        CPW_MODE_CLEAR: latch_nxt = 1'b0;
        CPW_MODE_SOFT: latch_nxt = latch_r;
        CPW_MODE_SPECIAL: latch_nxt = latch_r;
        default: latch_nxt = latch_r;
      endcase
    end
  end

  // ****************************************
  // Registers written by software
  // ****************************************
  assign uc_nxt = wr_uc ? wdata_i : uc_r;
  assign cvl_nxt = wr_cvl ? wdata_i : cvl_r;
  assign cvh_nxt = wr_cvh ? wdata_i : cvh_r;
  assign period_nxt = wr_pr ? wdata_i : period_r;
  assign tbc_nxt = wr_tbc ? wdata_i[2:0] : tbc_r;
  assign remap_nxt = wr_rm ? wdata_i[$clog2(PIN_COUNT)-1:0] : remap_r;
  assign dir_nxt = wr_dir ? wdata_i[0] : dir_r;

  // ****************************************
  // PWM generator
  // ****************************************
  assign pwm_bus.enable = pwm_mode;
  assign pwm_bus.period = period_r;
  assign pwm_bus.tb_ctrl = tbc_r;
  assign pwm_bus.duty = {cvl_r, uc_r[`CPW_UC_DUTY_LSB +: 2]};

  cpw_pwm u_pwm (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .pw(pwm_bus.pwm)
  );

  // ****************************************
  // Read path
  // ****************************************
  wire [7:0] status = {6'h00, ovf_r, match_r};
  wire [7:0] cvh_view = pwm_mode ? pwm_bus.duty_latched : cvh_r;

  always_comb
  begin
    rdata_nxt = 8'h00;
    if (rd_i)
    begin
      case (addr_i)
        `CPW_OFF_UNIT_CONTROL: rdata_nxt = uc_r;
        `CPW_OFF_CMP_LOW: rdata_nxt = cvl_r;
        `CPW_OFF_CMP_HIGH: rdata_nxt = cvh_view;
        `CPW_OFF_TMRA_LOW: rdata_nxt = tmra_r[7:0];
        `CPW_OFF_TMRA_HIGH: rdata_nxt = tmra_r[15:8];
        `CPW_OFF_STATUS: rdata_nxt = status;
        `CPW_OFF_PERIOD: rdata_nxt = period_r;
        `CPW_OFF_TMRB_CTRL: rdata_nxt = {5'h00, tbc_r};
        `CPW_OFF_PIN_REMAP: rdata_nxt = 8'(remap_r);
        `CPW_OFF_PIN_DIR: rdata_nxt = {7'h00, dir_r};
        `CPW_OFF_TMRB_COUNT: rdata_nxt = pwm_bus.tb_count;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // ****************************************
  // Flops
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      uc_r <= `CPW_RST_BYTE;
      cvl_r <= `CPW_RST_BYTE;
      cvh_r <= `CPW_RST_BYTE;
      period_r <= `CPW_RST_PERIOD;
      tbc_r <= `CPW_RST_TBC;
      dir_r <= `CPW_RST_DIR;
      rdata_r <= `CPW_RST_BYTE;
    end
    else
    begin
      uc_r <= uc_nxt;
      cvl_r <= cvl_nxt;
      cvh_r <= cvh_nxt;
      period_r <= period_nxt;
      tbc_r <= tbc_nxt;
      dir_r <= dir_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      tmra_r <= `CPW_RST_WORD;
      match_r <= 1'b0;
      ovf_r <= 1'b0;
      eq_prev_r <= 1'b0;
      latch_r <= 1'b0;
      remap_r <= '0;
      sev_r <= CPW_SEV_IDLE;
    end
    else
    begin
      tmra_r <= tmra_nxt;
      match_r <= match_nxt;
      ovf_r <= ovf_nxt;
      eq_prev_r <= eq;
      latch_r <= latch_nxt;
      remap_r <= remap_nxt;
      sev_r <= sev_nxt;
    end
  end

  // ****************************************
  // Pin steering
  // ****************************************
  // Zero unit_control leaves no owning mode, so the pin is let go
  wire owns_pin = pwm_mode | (mode == CPW_MODE_TOGGLE) |
                  (mode == CPW_MODE_SET) | (mode == CPW_MODE_CLEAR);
  // A released pin shows low, even while the latch clears a cycle later
  wire pin_level = owns_pin & (pwm_mode ? pwm_bus.pwm_level : latch_r);
  // Driver also needs the direction bit cleared by software
  wire drive = owns_pin & ~dir_r;

  always_comb
  begin
    unit_pin_o = '0;
    unit_pin_oe_o = '0;
    for (int i = 0; i < PIN_COUNT; i++)
    begin
      if (remap_r == i[$clog2(PIN_COUNT)-1:0])
      begin
        unit_pin_o[i] = pin_level;
        unit_pin_oe_o[i] = drive;
      end
    end
  end

  assign rdata_o = rdata_r;
  assign special_event_o = sev_ev;
  assign adc_start_o = sev_ev & adc_enable_i;
  assign match_flag_o = match_r;
  assign timer_a_overflow_flag_o = ovf_r;

endmodule : cpw_unit

// file: test/cpw_unit_checker.sv
`timescale 1ns/1ps
`include "cpw_consts.svh"

module cpw_unit_checker #(
  parameter int PIN_COUNT = 2
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire cpw_pkg::cpw_addr_t addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic timer_a_tick_i,
  input wire logic adc_enable_i,
  input wire logic special_event_o,
  input wire logic adc_start_o,
  input wire logic match_flag_o,
  input wire logic timer_a_overflow_flag_o,
  input wire logic [PIN_COUNT-1:0] unit_pin_o,
  input wire logic [PIN_COUNT-1:0] unit_pin_oe_o
);
  import cpw_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);

  a_adc_gated: assert property (adc_start_o == (special_event_o & adc_enable_i))
    else $error("converter start not gated by trigger");
  a_event_single: assert property (special_event_o |=> !special_event_o)
    else $error("trigger longer than one cycle");
  a_event_flags: assert property (special_event_o |=> match_flag_o)
    else $error("trigger without match flag");
  a_no_ovf: assert property (special_event_o && !timer_a_overflow_flag_o
    |=> !timer_a_overflow_flag_o [*4])
    else $error("overflow flag after trigger");
  a_one_pin: assert property ($onehot0(unit_pin_oe_o) && $onehot0(unit_pin_o))
    else $error("more than one pin active");
  a_reset_clear: assert property ($fell(srst_i)
    |-> unit_pin_o == '0 && unit_pin_oe_o == '0 && !match_flag_o)
    else $error("outputs not cleared by reset");
  a_flag_hold: assert property (match_flag_o
    && !(wr_i && addr_i == `CPW_OFF_STATUS && wdata_i[0]) |=> match_flag_o)
    else $error("match flag lost");
  a_ctrl_release: assert property (wr_i && addr_i == `CPW_OFF_UNIT_CONTROL
    && wdata_i == 8'h00 |=> unit_pin_oe_o == '0 && unit_pin_o == '0)
    else $error("pin kept after control cleared");
endmodule : cpw_unit_checker

bind cpw_unit cpw_unit_checker #(.PIN_COUNT(PIN_COUNT)) cpw_unit_checker_i (
  .clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .timer_a_tick_i(timer_a_tick_i),
  .adc_enable_i(adc_enable_i), .special_event_o(special_event_o), .adc_start_o(adc_start_o),
  .match_flag_o(match_flag_o), .timer_a_overflow_flag_o(timer_a_overflow_flag_o),
  .unit_pin_o(unit_pin_o), .unit_pin_oe_o(unit_pin_oe_o));

// file: test/cpw_timer_model.sv
`timescale 1ns/1ps

module cpw_timer_model (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic run_i,
  input wire logic adc_start_i,
  output logic tick_o,
  output int n_conv_o
);
  logic [1:0] div_r;

  // Tick every fourth clock, in step with clk_i
  always_ff @(posedge clk_i)
  begin
    div_r <= srst_i ? 2'h0 : div_r + 2'h1;
    tick_o <= !srst_i && run_i && div_r == 2'h3;
    n_conv_o <= srst_i ? 0 : n_conv_o + int'(adc_start_i === 1'b1);
  end
endmodule : cpw_timer_model

// file: test/tb.sv
`timescale 1ns/1ps
`include "cpw_consts.svh"

module tb;
  import cpw_pkg::*;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  cpw_addr_t addr_i = '0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic run = 1'b0;
  logic adc_en = 1'b1;
  logic [7:0] rdata_o;
  logic tick, sev, adc_start, flag, ovf;
  logic [1:0] unit_pin_o, unit_pin_oe_o;
  int n_conv, n_sev = 0, n_mismatch = 0, cmp_count = 0;
  cpw_mode_t md [5] = '{CPW_MODE_TOGGLE, CPW_MODE_SET, CPW_MODE_CLEAR, CPW_MODE_SOFT,
    CPW_MODE_SPECIAL};

  cpw_unit #(.PIN_COUNT(2)) cpw_unit_i (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .timer_a_tick_i(tick),
    .adc_enable_i(adc_en), .special_event_o(sev), .adc_start_o(adc_start),
    .match_flag_o(flag), .timer_a_overflow_flag_o(ovf), .unit_pin_o(unit_pin_o),
    .unit_pin_oe_o(unit_pin_oe_o));
  cpw_timer_model cpw_timer_model_i (.clk_i(clk_i), .srst_i(srst_i), .run_i(run),
    .adc_start_i(adc_start), .tick_o(tick), .n_conv_o(n_conv));

  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input cpw_addr_t a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask : wr

  task automatic rdc(input cpw_addr_t a, input logic [7:0] exp);
    logic [7:0] v;
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    v = rdata_o;
    @(posedge clk_i);
    chk({8'h00, v}, {8'h00, exp});
  endtask : rdc

  task automatic pins(input logic [3:0] exp);
    @(negedge clk_i);
    chk({12'h000, unit_pin_o, unit_pin_oe_o}, {12'h000, exp});
    @(posedge clk_i);
  endtask : pins

  // Counts high cycles over four whole periods of 16 clocks
  task automatic pwm(input logic [7:0] cvl, input logic [1:0] db, input int exp);
    int hi;
    hi = 0;
    wr(`CPW_OFF_CMP_LOW, cvl);
    wr(`CPW_OFF_UNIT_CONTROL, {2'b00, db, 4'hC});
    repeat (40) @(posedge clk_i);
    repeat (64) @(negedge clk_i) hi += int'(unit_pin_o[0] === 1'b1);
    chk(16'(hi), 16'(exp));
  endtask : pwm

  task automatic stop_test();
    $display("comparisons=%0d mismatches=%0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test

  initial
  begin
    forever #50 clk_i = ~clk_i;
  end

  always @(negedge clk_i) n_sev += int'(sev === 1'b1);

  initial
  begin
    repeat (5000) @(posedge clk_i);
    n_mismatch++;
    stop_test();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    logic [1:0] b;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    rdc(`CPW_OFF_UNIT_CONTROL, 8'h00);
    rdc(`CPW_OFF_PERIOD, 8'hFF);
    rdc(`CPW_OFF_PIN_DIR, 8'h01);
    rdc(4'hF, 8'h00);
    wr(`CPW_OFF_PIN_DIR, 8'h00);
    wr(`CPW_OFF_CMP_HIGH, 8'h12);
    wr(`CPW_OFF_CMP_LOW, 8'h34);
    // Timer held still, so equality persists after each match
    for (int i = 0; i < 5; i++)
    begin
      b = 2'b01 << i[0];
      wr(`CPW_OFF_UNIT_CONTROL, 8'h00);
      pins(4'h0);
      wr(`CPW_OFF_TMRA_HIGH, 8'h00);
      wr(`CPW_OFF_STATUS, 8'h03);
      wr(`CPW_OFF_PIN_REMAP, {7'h00, i[0]});
      wr(`CPW_OFF_UNIT_CONTROL, {4'h0, md[i]});
      wr(`CPW_OFF_TMRA_HIGH, 8'h12);
      wr(`CPW_OFF_TMRA_LOW, 8'h34);
      repeat (8) @(posedge clk_i);
      pins({(i < 2) ? b : 2'b00, (i < 3) ? b : 2'b00});
      chk({15'h0000, flag}, 16'h0001);
      rdc(`CPW_OFF_STATUS, 8'h01);
      wr(`CPW_OFF_STATUS, 8'h01);
      rdc(`CPW_OFF_STATUS, 8'h00);
    end
    chk(16'(n_sev), 16'd1);
    run <= 1'b1;
    repeat (6) @(posedge clk_i);
    run <= 1'b0;
    rdc(`CPW_OFF_TMRA_HIGH, 8'h00);
    rdc(`CPW_OFF_STATUS, 8'h00);
    chk({15'h0000, ovf}, 16'h0000);
    wr(`CPW_OFF_TMRA_HIGH, 8'h12);
    wr(`CPW_OFF_TMRA_LOW, 8'h34);
    wr(`CPW_OFF_CMP_LOW, 8'h30);
    run <= 1'b1;
    repeat (6) @(posedge clk_i);
    run <= 1'b0;
    rdc(`CPW_OFF_TMRA_HIGH, 8'h12);
    chk(16'(n_sev), 16'd2);
    chk(16'(n_conv), 16'd2);
    wr(`CPW_OFF_PERIOD, 8'h03);
    wr(`CPW_OFF_TMRB_CTRL, 8'h04);
    pwm(8'h01, 2'b10, 24);
    rdc(`CPW_OFF_CMP_HIGH, 8'h01);
    pwm(8'h00, 2'b00, 0);
    wr(`CPW_OFF_UNIT_CONTROL, 8'h00);
    pins(4'h0);
    stop_test();
  end
endmodule : tb
